// [iep_pkg.sv]
// Constants for the interrupt enable and priority block.
// Assumes an 8-bit special-function register port from the core.
package iep_pkg;

   localparam int          N_SRC          = 14;
   localparam int          SRC_W          = 4;
   localparam int          LVL_W          = 2;
   localparam int          N_LVL          = 4;

   // Register addresses
   localparam logic [7:0]  ADDR_EXT_EN    = 8'ha9;
   localparam logic [7:0]  ADDR_LEG_LO    = 8'hb8;
   localparam logic [7:0]  ADDR_LEG_HI    = 8'hb9;
   localparam logic [7:0]  ADDR_EXT_LO    = 8'hba;
   localparam logic [7:0]  ADDR_EXT_HI    = 8'hbb;

   // Reset values and implemented bits
   localparam logic [7:0]  RST_EXT_EN     = 8'h00;
   localparam logic [7:0]  RST_LEG        = 8'h00;
   localparam logic [7:0]  RST_EXT_PRIO   = 8'h00;
   localparam logic [7:0]  LEG_MASK       = 8'h3f;

   // Bit positions in the legacy priority pair
   localparam int          B_EXT_PIN_ZERO = 0;
   localparam int          B_TIMER_ZERO   = 1;
   localparam int          B_EXT_PIN_ONE  = 2;
   localparam int          B_TIMER_ONE    = 3;
   localparam int          B_UART_ONE     = 4;
   localparam int          B_TIMER_TWO    = 5;

   // Bit positions in the extended enable and priority registers
   localparam int          B_TIMER_THREE  = 0;
   localparam int          B_PORT_ONE     = 1;
   localparam int          B_PINS_LOWVOLT = 2;
   localparam int          B_ADC_TOUCH    = 3;
   localparam int          B_SERIAL_PERIPH = 4;
   localparam int          B_UART_TWO     = 5;
   localparam int          B_TWO_WIRE     = 6;
   localparam int          B_PWM_GROUP    = 7;

   // Source indices, also the fixed polling order (lowest first)
   localparam logic [SRC_W-1:0] SRC_EXT_PIN_ZERO = 4'h0;
   localparam logic [SRC_W-1:0] SRC_TIMER_ZERO   = 4'h1;
   localparam logic [SRC_W-1:0] SRC_EXT_PIN_ONE  = 4'h2;
   localparam logic [SRC_W-1:0] SRC_TIMER_ONE    = 4'h3;
   localparam logic [SRC_W-1:0] SRC_UART_ONE     = 4'h4;
   localparam logic [SRC_W-1:0] SRC_TIMER_TWO    = 4'h5;
   localparam logic [SRC_W-1:0] SRC_TIMER_THREE  = 4'h6;
   localparam logic [SRC_W-1:0] SRC_PORT_ONE     = 4'h7;
   localparam logic [SRC_W-1:0] SRC_PINS_LOWVOLT = 4'h8;
   localparam logic [SRC_W-1:0] SRC_ADC_TOUCH    = 4'h9;
   localparam logic [SRC_W-1:0] SRC_SERIAL_PERIPH = 4'ha;
   localparam logic [SRC_W-1:0] SRC_UART_TWO     = 4'hb;
   localparam logic [SRC_W-1:0] SRC_TWO_WIRE     = 4'hc;
   localparam logic [SRC_W-1:0] SRC_PWM_GROUP    = 4'hd;
   localparam int          N_LEGACY       = 6;
   localparam int          N_PERIPH       = 13;

endpackage

// [iep_arbiter.sv]
// Picks the highest priority pending source; ties go to the lowest index.
// Assumes requests are already gated and levels packed two bits per source.
`timescale 1ns/1ns
`default_nettype none
module iep_arbiter #(
   parameter int N  = 14,
   parameter int IW = 4,
   parameter int LW = 2
) (
   input  wire logic [N-1:0]    req_i,
   input  wire logic [N*LW-1:0] levels_i,
   output logic                 valid_o,
   output logic [IW-1:0]        idx_o,
   output logic [LW-1:0]        level_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Scan from the top so that lower indices win equal levels
   always_comb begin
      valid_o = 1'b0;
      idx_o   = '0;
      level_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_i[i] && (!valid_o || levels_i[i*LW +: LW] >= level_o)) begin
            valid_o = 1'b1;
            idx_o   = IW'(i);
            level_o = levels_i[i*LW +: LW];
         end
      end
   end

endmodule
`default_nettype wire

// [iep_irq_ctrl.sv]
// Interrupt enable and four-level priority block with its register port.
// Assumes flags, edge detection and legacy enables live in other blocks.
`timescale 1ns/1ns
`default_nettype none
module iep_irq_ctrl
   import iep_pkg::*;
#(
   parameter int N_PWM = 3
) (
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   input  wire logic               ce_i,
   // Register port
   input  wire logic [7:0]         sfr_addr_i,
   input  wire logic               sfr_wr_i,
   input  wire logic               sfr_rd_i,
   input  wire logic [7:0]         sfr_wdata_i,
   output logic [7:0]              sfr_rdata_o,
   output logic                    sfr_hit_o,
   // Enables held elsewhere
   input  wire logic               global_irq_gate_i,
   input  wire logic [N_LEGACY-1:0] legacy_en_i,
   // Request flags
   input  wire logic [N_PERIPH-1:0] periph_req_i,
   input  wire logic [N_PWM-1:0]   pwm_chan_req_i,
   input  wire logic [N_PWM-1:0]   pwm_chan_en_i,
   // Wake sources
   input  wire logic [7:0]         pins_wake_i,
   input  wire logic               port1_wake_i,
   output logic                    wake_o,
   // Core side
   input  wire logic               irq_ack_i,
   input  wire logic               irq_ret_i,
   output logic                    irq_req_o,
   output logic [SRC_W-1:0]        irq_source_o,
   output logic [LVL_W-1:0]        irq_level_o
);

   logic [7:0]             ext_en_q;
   logic [7:0]             leg_lo_q;
   logic [7:0]             leg_hi_q;
   logic [7:0]             ext_lo_q;
   logic [7:0]             ext_hi_q;
   logic [7:0]             rdata_q;
   logic [N_SRC*LVL_W-1:0] lvl_flat;
   logic [N_SRC-1:0]       raw_req;
   logic [N_SRC-1:0]       src_en;
   logic [N_SRC-1:0]       gated_req;
   logic                   pwm_req;
   logic                   win_valid;
   logic [SRC_W-1:0]       win_idx;
   logic [LVL_W-1:0]       win_level;
   logic [N_LVL-1:0]       svc_q;
   logic [N_LVL-1:0]       svc_d;
   logic                   req_d;
   logic                   req_q;
   logic [SRC_W-1:0]       src_q;
   logic [LVL_W-1:0]       lvl_q;
   logic                   wake_q;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [LVL_W-1:0] prio_pair(input logic hi, input logic lo);
      return {hi, lo};
   endfunction

   function automatic logic is_ours(input logic [7:0] a);
      return (a == ADDR_EXT_EN) || (a == ADDR_LEG_LO) || (a == ADDR_LEG_HI) ||
             (a == ADDR_EXT_LO) || (a == ADDR_EXT_HI);
   endfunction

   function automatic logic [LVL_W-1:0] top_level(input logic [N_LVL-1:0] s);
      logic [LVL_W-1:0] r;
      r = '0;
      for (int i = 0; i < N_LVL; i++) begin
         if (s[i]) begin
            r = LVL_W'(i);
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ext_en_q <= RST_EXT_EN;
         leg_lo_q <= RST_LEG;
         leg_hi_q <= RST_LEG;
         ext_lo_q <= RST_EXT_PRIO;
         ext_hi_q <= RST_EXT_PRIO;
      end else if (ce_i && sfr_wr_i) begin
         case (sfr_addr_i)
            ADDR_EXT_EN: begin
               ext_en_q <= sfr_wdata_i;
            end
            ADDR_LEG_LO: begin
               leg_lo_q <= sfr_wdata_i & LEG_MASK;
            end
            ADDR_LEG_HI: begin
               leg_hi_q <= sfr_wdata_i & LEG_MASK;
            end
            ADDR_EXT_LO: begin
               ext_lo_q <= sfr_wdata_i;
            end
            ADDR_EXT_HI: begin
               ext_hi_q <= sfr_wdata_i;
            end
            default: begin
               ext_en_q <= ext_en_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads, captured one edge after the read strobe
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (ce_i && sfr_rd_i) begin
         case (sfr_addr_i)
            ADDR_EXT_EN: rdata_q <= ext_en_q;
            ADDR_LEG_LO: rdata_q <= leg_lo_q;
            ADDR_LEG_HI: rdata_q <= leg_hi_q;
            ADDR_EXT_LO: rdata_q <= ext_lo_q;
            ADDR_EXT_HI: rdata_q <= ext_hi_q;
            default:     rdata_q <= 8'h00;
         endcase
      end
   end

   assign sfr_rdata_o = rdata_q;
   assign sfr_hit_o   = is_ours(sfr_addr_i);

   ////////////////////////////////////////////////////////////////////////////
   // Per-source priority levels
   assign lvl_flat[SRC_TIMER_TWO*LVL_W +: LVL_W] =
      prio_pair(leg_hi_q[B_TIMER_TWO], leg_lo_q[B_TIMER_TWO]);
   assign lvl_flat[SRC_UART_ONE*LVL_W +: LVL_W] =
      prio_pair(leg_hi_q[B_UART_ONE], leg_lo_q[B_UART_ONE]);
   assign lvl_flat[SRC_TIMER_ONE*LVL_W +: LVL_W] =
      prio_pair(leg_hi_q[B_TIMER_ONE], leg_lo_q[B_TIMER_ONE]);
   assign lvl_flat[SRC_EXT_PIN_ONE*LVL_W +: LVL_W] =
      prio_pair(leg_hi_q[B_EXT_PIN_ONE], leg_lo_q[B_EXT_PIN_ONE]);
   assign lvl_flat[SRC_TIMER_ZERO*LVL_W +: LVL_W] =
      prio_pair(leg_hi_q[B_TIMER_ZERO], leg_lo_q[B_TIMER_ZERO]);
   assign lvl_flat[SRC_EXT_PIN_ZERO*LVL_W +: LVL_W] =
      prio_pair(leg_hi_q[B_EXT_PIN_ZERO], leg_lo_q[B_EXT_PIN_ZERO]);
   assign lvl_flat[SRC_PWM_GROUP*LVL_W +: LVL_W] =
      prio_pair(ext_hi_q[B_PWM_GROUP], ext_lo_q[B_PWM_GROUP]);
   assign lvl_flat[SRC_TWO_WIRE*LVL_W +: LVL_W] =
      prio_pair(ext_hi_q[B_TWO_WIRE], ext_lo_q[B_TWO_WIRE]);
   assign lvl_flat[SRC_UART_TWO*LVL_W +: LVL_W] =
      prio_pair(ext_hi_q[B_UART_TWO], ext_lo_q[B_UART_TWO]);
   assign lvl_flat[SRC_SERIAL_PERIPH*LVL_W +: LVL_W] =
      prio_pair(ext_hi_q[B_SERIAL_PERIPH], ext_lo_q[B_SERIAL_PERIPH]);
   assign lvl_flat[SRC_ADC_TOUCH*LVL_W +: LVL_W] =
      prio_pair(ext_hi_q[B_ADC_TOUCH], ext_lo_q[B_ADC_TOUCH]);
   assign lvl_flat[SRC_PINS_LOWVOLT*LVL_W +: LVL_W] =
      prio_pair(ext_hi_q[B_PINS_LOWVOLT], ext_lo_q[B_PINS_LOWVOLT]);
   assign lvl_flat[SRC_PORT_ONE*LVL_W +: LVL_W] =
      prio_pair(ext_hi_q[B_PORT_ONE], ext_lo_q[B_PORT_ONE]);
   assign lvl_flat[SRC_TIMER_THREE*LVL_W +: LVL_W] =
      prio_pair(ext_hi_q[B_TIMER_THREE], ext_lo_q[B_TIMER_THREE]);

   ////////////////////////////////////////////////////////////////////////////
   // Request gating; extended enable bit n gates source 6+n
   assign pwm_req   = |(pwm_chan_req_i & pwm_chan_en_i);
   assign raw_req   = {pwm_req, periph_req_i};
   assign src_en    = {ext_en_q, legacy_en_i};
   assign gated_req = raw_req & src_en & {N_SRC{global_irq_gate_i}};

   iep_arbiter #(
      .N  (N_SRC),
      .IW (SRC_W),
      .LW (LVL_W)
   ) u_arb (
      .req_i    (gated_req),
      .levels_i (lvl_flat),
      .valid_o  (win_valid),
      .idx_o    (win_idx),
      .level_o  (win_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // In-service levels: a return retires the highest, an acknowledge adds one
   always_comb begin
      svc_d = svc_q;
      if (irq_ret_i && (|svc_q)) begin
         svc_d[top_level(svc_q)] = 1'b0;
      end
      if (irq_ack_i && req_q) begin
         svc_d[lvl_q] = 1'b1;
      end
   end

   assign req_d = win_valid && (!(|svc_d) || (win_level > top_level(svc_d)));

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         svc_q <= '0;
      end else if (ce_i) begin
         svc_q <= svc_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         req_q <= 1'b0;
         src_q <= '0;
         lvl_q <= '0;
      end else if (ce_i) begin
         req_q <= req_d;
         src_q <= win_idx;
         lvl_q <= win_level;
      end
   end

   assign irq_req_o    = req_q;
   assign irq_source_o = src_q;
   assign irq_level_o  = lvl_q;

   ////////////////////////////////////////////////////////////////////////////
   // Wake from halt or stop, independent of the global gate
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wake_q <= 1'b0;
      end else if (ce_i) begin
         wake_q <= ((|pins_wake_i) && ext_en_q[B_PINS_LOWVOLT]) || port1_wake_i;
      end
   end

   assign wake_o = wake_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   a_top_pair_level: assert property (
      gated_req[SRC_TIMER_THREE] && ext_hi_q[B_TIMER_THREE] && ext_lo_q[B_TIMER_THREE]
      |-> win_valid && (win_level == 2'h3))
      else $error("Pair 11 did not give level 3");

   a_pair_encoding: assert property (
      lvl_flat[SRC_TIMER_THREE*LVL_W +: LVL_W] ==
      (ext_hi_q[B_TIMER_THREE] ? (ext_lo_q[B_TIMER_THREE] ? 2'h3 : 2'h2) :
       (ext_lo_q[B_TIMER_THREE] ? 2'h1 : 2'h0)))
      else $error("Priority pair encoding broken");

   a_timer_two_map: assert property (
      ce_i && sfr_wr_i && (sfr_addr_i == ADDR_LEG_HI) |=>
      lvl_flat[SRC_TIMER_TWO*LVL_W + 1] == $past(sfr_wdata_i[B_TIMER_TWO]))
      else $error("Timer 2 high bit not mapped");

   a_timer_three_map: assert property (
      ce_i && sfr_wr_i && (sfr_addr_i == ADDR_EXT_LO) |=>
      lvl_flat[SRC_TIMER_THREE*LVL_W] == $past(sfr_wdata_i[B_TIMER_THREE]))
      else $error("Timer 3 low bit not mapped");

   a_uart_two_gate: assert property (
      win_valid && (win_idx == SRC_UART_TWO) |-> ext_en_q[B_UART_TWO])
      else $error("Second UART passed while disabled");

   a_spi_gate: assert property (
      win_valid && (win_idx == SRC_SERIAL_PERIPH) |-> ext_en_q[B_SERIAL_PERIPH])
      else $error("Serial peripheral passed while disabled");

   a_global_block: assert property (
      ce_i && !global_irq_gate_i && !(|svc_q) |=> !irq_req_o)
      else $error("Request passed with global gate low");

   a_pwm_both: assert property (
      win_valid && (win_idx == SRC_PWM_GROUP) |->
      ext_en_q[B_PWM_GROUP] && (|(pwm_chan_req_i & pwm_chan_en_i)))
      else $error("PWM passed without both enables");

   a_pins_wake: assert property (
      ce_i && (|pins_wake_i) && ext_en_q[B_PINS_LOWVOLT] |=> wake_o)
      else $error("Pin wake lost");

   a_port_one_wake: assert property (
      ce_i && port1_wake_i |=> wake_o)
      else $error("Port 1 wake blocked");

   a_preempt_only: assert property (
      irq_req_o && (|svc_q) |-> irq_level_o > top_level(svc_q))
      else $error("Request did not outrank service level");

endmodule
`default_nettype wire

// [iep_core_model.sv]
// Behavioural stand-in for the processor core on the far side of the block.
// Assumes the bench tells it when to accept requests and when to return.
`timescale 1ns/1ns
`default_nettype none
module iep_core_model (
   input  wire logic       ref_clk_i,
   input  wire logic       irq_req_i,
   input  wire logic       ack_en_i,
   input  wire logic [3:0] ack_delay_i,
   input  wire logic       ret_cmd_i,
   output logic            irq_ack_o,
   output logic            irq_ret_o
);
   logic busy;

   ////////////////////////////////////////////////////////////////////////////
   // Accept one request at a time, then return when told to
   initial begin
      irq_ack_o = 1'b0;
      irq_ret_o = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge ref_clk_i);
         if (ret_cmd_i && busy) begin
            @(negedge ref_clk_i);
            irq_ret_o = 1'b1;
            busy = 1'b0;
            @(negedge ref_clk_i);
            irq_ret_o = 1'b0;
         end else if (ack_en_i && irq_req_i && !busy) begin
            repeat (ack_delay_i) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            irq_ack_o = 1'b1;
            busy = 1'b1;
            @(negedge ref_clk_i);
            irq_ack_o = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [iep_irq_ctrl_tb.sv]
// Self-checking bench for the interrupt enable and priority block.
// Assumes the core model file is compiled first; one 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module iep_irq_ctrl_tb;
   import iep_pkg::*;

   logic                ref_clk_i;
   logic                rst_i;
   logic                ce_i;
   logic [7:0]          sfr_addr_i;
   logic                sfr_wr_i;
   logic                sfr_rd_i;
   logic [7:0]          sfr_wdata_i;
   logic [7:0]          sfr_rdata_o;
   logic                sfr_hit_o;
   logic                global_irq_gate_i;
   logic [N_LEGACY-1:0] legacy_en_i;
   logic [N_PERIPH-1:0] periph_req_i;
   logic [2:0]          pwm_chan_req_i;
   logic [2:0]          pwm_chan_en_i;
   logic [7:0]          pins_wake_i;
   logic                port1_wake_i;
   logic                wake_o;
   wire                 irq_ack;
   wire                 irq_ret;
   logic                irq_req_o;
   logic [SRC_W-1:0]    irq_source_o;
   logic [LVL_W-1:0]    irq_level_o;
   logic                ack_en;
   logic [3:0]          ack_dly;
   logic                ret_cmd;
   int                  err_count;
   int                  checks_done;
   int                  s;
   int                  l;
   logic [7:0]          reg_a [5] = '{ADDR_EXT_EN, ADDR_LEG_LO, ADDR_LEG_HI, ADDR_EXT_LO,
                                      ADDR_EXT_HI};
   logic [7:0]          reg_m [5] = '{8'hff, LEG_MASK, LEG_MASK, 8'hff, 8'hff};

   iep_irq_ctrl #(.N_PWM(3)) dut_u (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
      .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
      .global_irq_gate_i(global_irq_gate_i), .legacy_en_i(legacy_en_i),
      .periph_req_i(periph_req_i), .pwm_chan_req_i(pwm_chan_req_i),
      .pwm_chan_en_i(pwm_chan_en_i), .pins_wake_i(pins_wake_i),
      .port1_wake_i(port1_wake_i), .wake_o(wake_o), .irq_ack_i(irq_ack),
      .irq_ret_i(irq_ret), .irq_req_o(irq_req_o), .irq_source_o(irq_source_o),
      .irq_level_o(irq_level_o));

   iep_core_model core_u (
      .ref_clk_i(ref_clk_i), .irq_req_i(irq_req_o), .ack_en_i(ack_en),
      .ack_delay_i(ack_dly), .ret_cmd_i(ret_cmd), .irq_ack_o(irq_ack),
      .irq_ret_o(irq_ret));

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   always #20 ref_clk_i = ~ref_clk_i;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge ref_clk_i);
      sfr_wr_i = 1'b0;
   endtask

   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      @(negedge ref_clk_i);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(negedge ref_clk_i);
      sfr_rd_i = 1'b0;
      chk(sfr_rdata_o, exp);
      chk({7'h00, sfr_hit_o}, {7'h00, hit});
   endtask

   task automatic set_req(input int src, input logic on);
      if (src < 13) periph_req_i[src] = on;
      else begin
         pwm_chan_req_i[0] = on;
         pwm_chan_en_i[0] = on;
      end
   endtask

   task automatic chk_irq(input logic req, input int src, input int lvl);
      chk({7'h00, irq_req_o}, {7'h00, req});
      chk({4'h0, irq_source_o}, 8'(src));
      chk({6'h00, irq_level_o}, 8'(lvl));
   endtask

   task automatic results;
      if (err_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #(40 * 6000);
      err_count++;
      results;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin
      ref_clk_i = 1'b0;
      rst_i = 1'b1;
      ce_i = 1'b1;
      sfr_addr_i = 8'h00;
      sfr_wr_i = 1'b0;
      sfr_rd_i = 1'b0;
      sfr_wdata_i = 8'h00;
      global_irq_gate_i = 1'b1;
      legacy_en_i = 6'h3f;
      periph_req_i = '0;
      pwm_chan_req_i = 3'h0;
      pwm_chan_en_i = 3'h0;
      pins_wake_i = 8'h00;
      port1_wake_i = 1'b0;
      ack_en = 1'b0;
      ack_dly = 4'h2;
      ret_cmd = 1'b0;
      err_count = 0;
      checks_done = 0;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      for (s = 0; s < 5; s++) sfr_rd(reg_a[s], 8'h00, 1'b1);
      for (s = 0; s < 5; s++) sfr_wr(reg_a[s], 8'hff);
      sfr_wr(8'ha8, 8'hff);
      for (s = 0; s < 5; s++) sfr_rd(reg_a[s], reg_m[s], 1'b1);
      sfr_rd(8'ha8, 8'h00, 1'b0);
      ce_i = 1'b0;
      sfr_wr(ADDR_EXT_LO, 8'h5a);
      ce_i = 1'b1;
      sfr_rd(ADDR_EXT_LO, 8'hff, 1'b1);
      // Global gate low holds source 0 back; so does clearing its legacy enable
      global_irq_gate_i = 1'b0;
      set_req(0, 1'b1);
      repeat (2) @(negedge ref_clk_i);
      chk({7'h00, irq_req_o}, 8'h00);
      global_irq_gate_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      chk({7'h00, irq_req_o}, 8'h01);
      legacy_en_i = 6'h3e;
      repeat (2) @(negedge ref_clk_i);
      chk({7'h00, irq_req_o}, 8'h00);
      legacy_en_i = 6'h3f;
      set_req(0, 1'b0);
      // Every source at every level, then for sources 6 to 13 its extended enable cleared
      for (s = 0; s < 14; s++) begin
         for (l = 0; l < 4; l++) begin
            sfr_wr(s < 6 ? ADDR_LEG_HI : ADDR_EXT_HI, 8'(l / 2) << (s < 6 ? s : s - 6));
            sfr_wr(s < 6 ? ADDR_LEG_LO : ADDR_EXT_LO, 8'(l % 2) << (s < 6 ? s : s - 6));
            set_req(s, 1'b1);
            repeat (2) @(negedge ref_clk_i);
            chk_irq(1'b1, s, l);
            set_req(s, 1'b0);
         end
         if (s >= 6) begin
            sfr_wr(ADDR_EXT_EN, ~(8'h01 << (s - 6)));
            set_req(s, 1'b1);
            repeat (2) @(negedge ref_clk_i);
            chk({7'h00, irq_req_o}, 8'h00);
            set_req(s, 1'b0);
            sfr_wr(ADDR_EXT_EN, 8'hff);
         end
      end
      pwm_chan_req_i = 3'h4;
      repeat (2) @(negedge ref_clk_i);
      chk({7'h00, irq_req_o}, 8'h00);
      pwm_chan_req_i = 3'h0;
      // Wake paths
      sfr_wr(ADDR_EXT_EN, 8'h04);
      global_irq_gate_i = 1'b0;
      pins_wake_i = 8'h80;
      @(negedge ref_clk_i);
      chk({7'h00, wake_o}, 8'h01);
      pins_wake_i = 8'h00;
      sfr_wr(ADDR_EXT_EN, 8'h00);
      pins_wake_i = 8'h01;
      @(negedge ref_clk_i);
      chk({7'h00, wake_o}, 8'h00);
      pins_wake_i = 8'h00;
      port1_wake_i = 1'b1;
      @(negedge ref_clk_i);
      chk({7'h00, wake_o}, 8'h01);
      port1_wake_i = 1'b0;
      global_irq_gate_i = 1'b1;
      // Nesting: level 1 in service, equal held off, level 3 pre-empts
      sfr_wr(ADDR_LEG_HI, 8'h20);
      sfr_wr(ADDR_LEG_LO, 8'h38);
      ack_en = 1'b1;
      set_req(3, 1'b1);
      for (l = 0; l < 20 && irq_ack !== 1'b1; l++) @(posedge ref_clk_i);
      repeat (3) @(negedge ref_clk_i);
      chk({7'h00, irq_req_o}, 8'h00);
      set_req(4, 1'b1);
      repeat (3) @(negedge ref_clk_i);
      chk({7'h00, irq_req_o}, 8'h00);
      set_req(5, 1'b1);
      repeat (2) @(negedge ref_clk_i);
      chk_irq(1'b1, 5, 3);
      set_req(5, 1'b0);
      ack_en = 1'b0;
      ret_cmd = 1'b1;
      @(negedge ref_clk_i);
      ret_cmd = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      chk_irq(1'b1, 3, 1);
      // Mid-run reset clears the request and the registers
      rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      chk_irq(1'b0, 0, 0);
      rst_i = 1'b0;
      sfr_rd(ADDR_LEG_LO, 8'h00, 1'b1);
      results;
   end
endmodule
`default_nettype wire
